// file: core/charge_cycle_control.sv
// charge_cycle_control: mode, phase and cycle-start sequencing of the charger core
// assumes an external serial slave hands over field writes as one-cycle strobes
`default_nettype none
module charge_cycle_control
  import charge_cycle_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // host field writes
  input wire logic cfg_write,
  input var charge_cycle_pkg::charge_cfg_type cfg_data,
  input wire logic ctrl_write,
  input wire logic charge_disable_req,
  input wire logic high_impedance_request,
  input wire logic boost_req,
  // analog indications
  input var charge_cycle_pkg::sense_type sense_raw,
  // outputs
  output var charge_cycle_pkg::drive_type drive,
  output var charge_cycle_pkg::charge_cfg_type cfg_view,
  output var charge_cycle_pkg::mode_type mode,
  output var charge_cycle_pkg::phase_type phase,
  output logic [1:0] status_code,
  output logic cycle_start
);
  import charge_cycle_pkg::*;

  // comparator synchroniser and debounce
  logic [SENSE_W-1:0] sync_a;
  logic [SENSE_W-1:0] sync_b;
  logic [SENSE_W-1:0] stable;
  logic [SENSE_W-1:0] next_stable;
  logic [DB_W-1:0] db_count [SENSE_W];
  logic [DB_W-1:0] next_db_count [SENSE_W];
  sense_type sense;

  genvar gi;
  generate
    for (gi = 0; gi < SENSE_W; gi++) begin : g_db
      // a flag must hold a whole window; any bounce restarts it
      always_comb begin
        next_db_count[gi] = db_count[gi];
        next_stable[gi] = stable[gi];
        if (sync_b[gi] == stable[gi]) begin
          next_db_count[gi] = '0;
        end else if (db_count[gi] == DB_W'(DEBOUNCE_CYCLES - 1)) begin
          next_db_count[gi] = '0;
          next_stable[gi] = sync_b[gi];
        end else begin
          next_db_count[gi] = db_count[gi] + DB_W'(1);
        end
      end
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          db_count[gi] <= '0;
          stable[gi] <= 1'b0;
        end else if (clk_en) begin
          db_count[gi] <= next_db_count[gi];
          stable[gi] <= next_stable[gi];
        end
      end
    end
  endgenerate

  // two flops; only the second one feeds the debounce
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync_a <= '0;
      sync_b <= '0;
    end else if (clk_en) begin
      sync_a <= sense_raw;
      sync_b <= sync_a;
    end
  end

  assign sense = stable;

  // host fields and control
  charge_cfg_type cfg;
  charge_cfg_type next_cfg;
  logic disabled;
  logic next_disabled;
  logic hz_req;
  logic next_hz_req;
  logic boost;
  logic next_boost;
  logic por_seen;
  logic next_por_seen;
  logic host_restart;
  logic por_start;

  always_comb begin
    next_cfg = cfg;
    next_disabled = disabled;
    next_hz_req = hz_req;
    next_boost = boost;
    host_restart = 1'b0;
    if (cfg_write) begin
      next_cfg = cfg_data;
    end
    if (ctrl_write) begin
      next_disabled = charge_disable_req;
      next_hz_req = high_impedance_request;
      next_boost = boost_req;
      // restart on clearing a set disable or high-z bit
      host_restart = (disabled && !charge_disable_req) ||
                     (hz_req && !high_impedance_request);
    end
    // rising edge of the debounced supply flag while below_weak is set, one start per power-up
    next_por_seen = sense.supply_por_clear;
    por_start = sense.supply_por_clear && !por_seen && sense.below_weak;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg.input_current_limit <= INLIM_RESET;
      cfg.weak_battery_threshold <= WEAK_RESET;
      cfg.termination_enable <= TERM_EN_RESET;
      cfg.float_voltage_code <= FLOAT_CODE_RESET;
      cfg.charge_current_limit <= CHG_LIMIT_RESET;
      cfg.termination_current <= TERM_RESET;
      disabled <= 1'b0;
      hz_req <= 1'b0;
      boost <= 1'b0;
      por_seen <= 1'b0;
    end else if (clk_en) begin
      cfg <= next_cfg;
      disabled <= next_disabled;
      hz_req <= next_hz_req;
      boost <= next_boost;
      por_seen <= next_por_seen;
    end
  end

  // mode and phase sequencing
  mode_type next_mode;
  phase_type next_phase;
  logic [HOLD_W-1:0] hold_count;
  logic [HOLD_W-1:0] next_hold_count;
  logic start_now;

  // mode follows the bits as written, so a write answers next edge
  always_comb begin
    next_mode = MODE_HIGH_Z;
    if (next_hz_req) begin
      next_mode = MODE_HIGH_Z;
    end else if (next_boost) begin
      next_mode = MODE_BOOST;
    end else if (!next_disabled && sense.supply_por_clear) begin
      next_mode = MODE_CHARGE;
    end
  end

  always_comb begin
    next_phase = phase;
    next_hold_count = hold_count;
    start_now = 1'b0;
    if (next_mode != MODE_CHARGE) begin
      next_phase = PH_IDLE;
      next_hold_count = '0;
    end else begin
      case (phase)
        PH_IDLE: begin
          // entering charge mode from elsewhere starts a cycle too
          if (host_restart || por_start || mode != MODE_CHARGE) begin
            start_now = 1'b1;
            next_phase = PH_PRECHARGE;
          end
        end
        PH_PRECHARGE: begin
          // switching starts only once input power allows
          if (!sense.below_short && sense.input_power_ok) begin
            next_phase = PH_CONST_CURRENT;
          end
        end
        PH_CONST_CURRENT: begin
          // a sagging cell drops back to precharge
          if (sense.below_short) begin
            next_phase = PH_PRECHARGE;
          end else if (sense.at_float) begin
            next_phase = PH_VOLTAGE;
          end
        end
        PH_VOLTAGE: begin
          // without termination the float voltage simply holds
          if (cfg.termination_enable && sense.current_at_term) begin
            next_phase = PH_READY_CHECK;
            next_hold_count = '0;
          end else if (!sense.at_float) begin
            next_phase = PH_CONST_CURRENT;
          end
        end
        PH_READY_CHECK: begin
          // ready code stands for the whole window
          if (hold_count == HOLD_W'(READY_HOLD_CYCLES - 1)) begin
            next_hold_count = '0;
            // both battery and source must still be present
            if (sense.battery_present && sense.supply_por_clear) begin
              next_phase = PH_DONE;
            end else begin
              next_phase = PH_IDLE;
            end
          end else begin
            next_hold_count = hold_count + HOLD_W'(1);
          end
        end
        PH_DONE: begin
          // recharge flag already sits below float by the hysteresis
          if (sense.below_recharge) begin
            start_now = 1'b1;
            next_phase = PH_PRECHARGE;
          end
        end
        default: begin
          next_phase = PH_IDLE;
        end
      endcase
      if (host_restart && phase != PH_IDLE) begin
        start_now = 1'b1;
        next_phase = PH_PRECHARGE;
        next_hold_count = '0;
      end
    end
  end

  // drive computation
  drive_type next_drive;
  logic [1:0] next_status;
  logic [5:0] eff_code;

  // decoded from the fields being written, so they answer next edge
  always_comb begin
    eff_code = (next_cfg.float_voltage_code >= FLOAT_CODE_MAX) ? FLOAT_CODE_MAX
               : next_cfg.float_voltage_code;
    next_drive = '0;
    next_drive.float_voltage_mv = FLOAT_BASE_MV +
      13'(eff_code * FLOAT_STEP_MV);
    case (next_cfg.input_current_limit)
      INLIM_100MA: next_drive.input_limit_ma = INLIM_100MA_REF;
      INLIM_500MA: next_drive.input_limit_ma = INLIM_500MA_REF;
      INLIM_800MA: next_drive.input_limit_ma = INLIM_800MA_REF;
      default: next_drive.input_limit_ma = INLIM_NONE_REF;
    endcase
    next_drive.charge_current_limit = next_cfg.charge_current_limit;
    next_drive.termination_current = next_cfg.termination_current;
    next_drive.weak_battery_threshold = next_cfg.weak_battery_threshold;
    // foldback and special limit act only while switching
    next_drive.boost_on = (next_mode == MODE_BOOST);
    next_drive.linear_precharge_on = (next_phase == PH_PRECHARGE);
    next_drive.switcher_on = (next_phase == PH_CONST_CURRENT) ||
                             (next_phase == PH_VOLTAGE);
    next_drive.thermal_foldback = next_drive.switcher_on && sense.die_hot;
    next_drive.special_limit = next_drive.switcher_on &&
                               sense.supply_at_special;
    // status follows the phase being entered
    case (next_phase)
      PH_PRECHARGE, PH_CONST_CURRENT, PH_VOLTAGE: next_status = STATUS_CHARGING;
      PH_DONE: next_status = STATUS_DONE;
      default: next_status = STATUS_READY;
    endcase
  end

  // every output is a flop; all of it freezes while clk_en is low
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode <= MODE_HIGH_Z;
      phase <= PH_IDLE;
      hold_count <= '0;
      drive <= '0;
      cfg_view <= '0;
      status_code <= STATUS_READY;
      cycle_start <= 1'b0;
    end else if (clk_en) begin
      mode <= next_mode;
      phase <= next_phase;
      hold_count <= next_hold_count;
      drive <= next_drive;
      cfg_view <= next_cfg;
      status_code <= next_status;
      cycle_start <= start_now;
    end
  end
endmodule
`default_nettype wire

// file: core/charge_cycle_pkg.sv
// charge_cycle_pkg: constants and carrier types for the charge cycle control core
// assumes a 40 MHz core_clk and comparator flags already digital
`default_nettype none
package charge_cycle_pkg;
  localparam int CLK_HZ = 40000000;
  // debounce time for comparator flags, microseconds
  localparam int DEBOUNCE_US = 50;
  localparam int DEBOUNCE_CYCLES = (DEBOUNCE_US * (CLK_HZ / 1000000));
  // ready-state hold after termination, milliseconds
  localparam int READY_HOLD_MS = 500;
  localparam int READY_HOLD_CYCLES = READY_HOLD_MS * (CLK_HZ / 1000);
  localparam int DB_W = 12;
  localparam int HOLD_W = 25;

  // float voltage decode, millivolts
  localparam logic [12:0] FLOAT_BASE_MV = 13'h0DAC;
  localparam logic [12:0] FLOAT_STEP_MV = 13'h0014;
  localparam logic [5:0] FLOAT_CODE_MAX = 6'h2F;

  // input current limit codes
  localparam logic [1:0] INLIM_100MA = 2'h0;
  localparam logic [1:0] INLIM_500MA = 2'h1;
  localparam logic [1:0] INLIM_800MA = 2'h2;
  localparam logic [1:0] INLIM_NONE = 2'h3;
  localparam logic [9:0] INLIM_100MA_REF = 10'h064;
  localparam logic [9:0] INLIM_500MA_REF = 10'h1F4;
  localparam logic [9:0] INLIM_800MA_REF = 10'h320;
  localparam logic [9:0] INLIM_NONE_REF = 10'h3FF;

  // status codes
  localparam logic [1:0] STATUS_READY = 2'h0;
  localparam logic [1:0] STATUS_CHARGING = 2'h1;
  localparam logic [1:0] STATUS_DONE = 2'h2;
  localparam logic [1:0] STATUS_FAULT = 2'h3;

  // reset values of the host fields
  localparam logic [5:0] FLOAT_CODE_RESET = 6'h02;
  localparam logic [1:0] INLIM_RESET = 2'h0;
  localparam logic [2:0] CHG_LIMIT_RESET = 3'h0;
  localparam logic [2:0] TERM_RESET = 3'h1;
  localparam logic [1:0] WEAK_RESET = 2'h1;
  localparam logic TERM_EN_RESET = 1'b0;

  typedef enum logic [1:0] {
    MODE_HIGH_Z = 2'b00,
    MODE_CHARGE = 2'b01,
    MODE_BOOST = 2'b10
  } mode_type;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_PRECHARGE = 3'b001,
    PH_CONST_CURRENT = 3'b010,
    PH_VOLTAGE = 3'b011,
    PH_READY_CHECK = 3'b100,
    PH_DONE = 3'b101
  } phase_type;

  // host-programmed charging fields
  typedef struct packed {
    logic [1:0] input_current_limit;
    logic [1:0] weak_battery_threshold;
    logic termination_enable;
    logic [5:0] float_voltage_code;
    logic [2:0] charge_current_limit;
    logic [2:0] termination_current;
  } charge_cfg_type;

  // raw comparator indications
  typedef struct packed {
    logic below_short;
    logic at_float;
    logic below_recharge;
    logic below_weak;
    logic current_at_term;
    logic die_hot;
    logic supply_at_special;
    logic input_power_ok;
    logic supply_por_clear;
    logic battery_present;
  } sense_type;
  localparam int SENSE_W = 10;

  // commands toward the analog loops
  typedef struct packed {
    logic linear_precharge_on;
    logic switcher_on;
    logic boost_on;
    logic thermal_foldback;
    logic special_limit;
    logic [9:0] input_limit_ma;
    logic [12:0] float_voltage_mv;
    logic [2:0] charge_current_limit;
    logic [2:0] termination_current;
    logic [1:0] weak_battery_threshold;
  } drive_type;
endpackage
`default_nettype wire

// file: verification/charge_cycle_asserts.sv
// checker: port timing relations of the charge cycle core
// assumes it is bound onto charge_cycle_control, one clock domain
`default_nettype none
module charge_cycle_asserts (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // host side
  input wire logic cfg_write,
  input var charge_cycle_pkg::charge_cfg_type cfg_data,
  // outputs
  input var charge_cycle_pkg::drive_type drive,
  input var charge_cycle_pkg::charge_cfg_type cfg_view,
  input var charge_cycle_pkg::mode_type mode,
  input var charge_cycle_pkg::phase_type phase,
  input wire logic [1:0] status_code,
  input wire logic cycle_start
);
  timeunit 1ns;
  timeprecision 1ps;
  import charge_cycle_pkg::*;
  localparam logic [9:0] ILIM [4] = '{10'h064, 10'h1F4, 10'h320, 10'h3FF};
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  function automatic logic [12:0] fv(input logic [5:0] c);
    return 13'h0DAC + 13'h0014 * ((c > 6'h2F) ? 13'h002F : {7'h00, c});
  endfunction
  AST_HIGHZ: assert property (mode == MODE_HIGH_Z |->
    !drive.switcher_on && !drive.linear_precharge_on && !drive.boost_on)
    else $error("path on in high-z");
  AST_BOOST: assert property (drive.boost_on |-> mode == MODE_BOOST)
    else $error("boost on outside boost mode");
  AST_PRE: assert property (phase == PH_PRECHARGE |->
    drive.linear_precharge_on && !drive.switcher_on)
    else $error("switcher during precharge");
  AST_FLOAT: assert property (clk_en && cfg_write |=>
    drive.float_voltage_mv == fv($past(cfg_data.float_voltage_code)))
    else $error("float voltage decode wrong");
  AST_INLIM: assert property (clk_en && cfg_write |=>
    drive.input_limit_ma == ILIM[$past(cfg_data.input_current_limit)])
    else $error("input limit decode wrong");
  AST_TE_OFF: assert property (clk_en && !cfg_write && !cfg_view.termination_enable
    && phase == PH_VOLTAGE |=> phase != PH_READY_CHECK)
    else $error("terminated with termination off");
  AST_READY: assert property (phase == PH_READY_CHECK |-> status_code == STATUS_READY)
    else $error("ready check without ready code");
  AST_HOLD: assert property ($rose(phase == PH_READY_CHECK) |=>
    (phase != PH_DONE && status_code != STATUS_DONE) [*8])
    else $error("ready check left early");
  AST_START: assert property (cycle_start |->
    mode == MODE_CHARGE && status_code == STATUS_CHARGING)
    else $error("cycle start outside charge");
  AST_PULSE: assert property (cycle_start && clk_en |=> !cycle_start)
    else $error("cycle start longer than one cycle");
  AST_FREEZE: assert property (!clk_en |=>
    $stable(phase) && $stable(mode) && $stable(status_code))
    else $error("state moved while frozen");
endmodule
bind charge_cycle_control charge_cycle_asserts charge_cycle_asserts_inst (
  .core_clk, .rst, .clk_en, .cfg_write, .cfg_data, .drive, .cfg_view, .mode, .phase,
  .status_code, .cycle_start);
`default_nettype wire

// file: verification/host_model.sv
// host_model: host side that hands field and control writes to the core
// assumes writes arrive as one-cycle strobes changed on the falling edge
`default_nettype none
module host_model (
  // clock
  input wire logic core_clk,
  // host writes
  output logic cfg_write,
  output var charge_cycle_pkg::charge_cfg_type cfg_data,
  output logic ctrl_write,
  output logic charge_disable_req,
  output logic high_impedance_request,
  output logic boost_req
);
  timeunit 1ns;
  timeprecision 1ps;
  import charge_cycle_pkg::*;
  initial begin
    cfg_write = 1'b0;
    cfg_data = '0;
    ctrl_write = 1'b0;
    {charge_disable_req, high_impedance_request, boost_req} = 3'h0;
  end
  task automatic cfg_wr(input charge_cfg_type d);
    @(negedge core_clk);
    cfg_write = 1'b1;
    cfg_data = d;
    @(negedge core_clk);
    cfg_write = 1'b0;
    // released data is not held
    cfg_data = ~d;
  endtask
  task automatic ctrl_wr(input logic dis, input logic hz, input logic bst);
    @(negedge core_clk);
    ctrl_write = 1'b1;
    {charge_disable_req, high_impedance_request, boost_req} = {dis, hz, bst};
    @(negedge core_clk);
    ctrl_write = 1'b0;
    {charge_disable_req, high_impedance_request, boost_req} = ~{dis, hz, bst};
  endtask
endmodule
`default_nettype wire

// file: verification/tb.sv
// tb: directed test of the charge cycle core
// assumes the host model and the bound checker are compiled alongside
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import charge_cycle_pkg::*;
  localparam int DB_WAIT = DEBOUNCE_CYCLES + 10;
  localparam int LIMIT = 20000;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic cfg_write, ctrl_write, charge_disable_req, high_impedance_request, boost_req;
  logic cycle_start;
  logic [1:0] status_code;
  sense_type sense_raw = '0;
  charge_cfg_type cfg_data, cfg_view, cfg;
  drive_type drive;
  mode_type mode;
  phase_type phase;
  logic [5:0] codes [7] = '{6'h00, 6'h01, 6'h23, 6'h2E, 6'h2F, 6'h30, 6'h3F};
  logic [9:0] lim [4] = '{INLIM_100MA_REF, INLIM_500MA_REF, INLIM_800MA_REF, INLIM_NONE_REF};
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  always #12.5 core_clk = ~core_clk;
  host_model host_model_inst (.core_clk, .cfg_write, .cfg_data, .ctrl_write,
    .charge_disable_req, .high_impedance_request, .boost_req);
  charge_cycle_control charge_cycle_control_inst (.core_clk, .rst, .clk_en, .cfg_write,
    .cfg_data, .ctrl_write, .charge_disable_req, .high_impedance_request, .boost_req,
    .sense_raw, .drive, .cfg_view, .mode, .phase, .status_code, .cycle_start);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    tick(6);
    rst = 1'b0;
    tick(2);
    cfg = {INLIM_RESET, WEAK_RESET, TERM_EN_RESET, FLOAT_CODE_RESET, CHG_LIMIT_RESET, TERM_RESET};
    check(cfg_view, cfg);
    check(mode, MODE_HIGH_Z);
    for (int i = 0; i < 7; i++) begin
      cfg.float_voltage_code = codes[i];
      cfg.input_current_limit = i[1:0];
      cfg.charge_current_limit = i[2:0];
      cfg.weak_battery_threshold = i[2:1];
      cfg.termination_current = i[2:0];
      host_model_inst.cfg_wr(cfg);
      check(cfg_view, cfg);
      check(drive.float_voltage_mv,
        13'h0DAC + 13'h0014 * (codes[i] > 6'h2F ? 6'h2F : codes[i]));
      check(drive.input_limit_ma, lim[i[1:0]]);
      check(drive.charge_current_limit, i[2:0]);
      check(drive.weak_battery_threshold, i[2:1]);
      check(drive.termination_current, i[2:0]);
    end
    cfg.termination_enable = 1'b0;
    host_model_inst.cfg_wr(cfg);
    // short, weak battery, supply up and valid
    sense_raw = 10'h247;
    tick(DEBOUNCE_CYCLES + 3);
    check(cycle_start, 1'b1);
    tick(DB_WAIT - DEBOUNCE_CYCLES - 3);
    check(mode, MODE_CHARGE);
    check(phase, PH_PRECHARGE);
    check(drive.linear_precharge_on, 1'b1);
    sense_raw.below_short = 1'b0;
    sense_raw.die_hot = 1'b1;
    sense_raw.supply_at_special = 1'b1;
    tick(DB_WAIT);
    check(phase, PH_CONST_CURRENT);
    check(drive.switcher_on, 1'b1);
    check(drive.thermal_foldback, 1'b1);
    check(drive.special_limit, 1'b1);
    sense_raw.at_float = 1'b1;
    sense_raw.current_at_term = 1'b1;
    tick(DB_WAIT);
    check(phase, PH_VOLTAGE);
    cfg.termination_enable = 1'b1;
    host_model_inst.cfg_wr(cfg);
    tick(4);
    check(phase, PH_READY_CHECK);
    check(status_code, STATUS_READY);
    clk_en = 1'b0;
    tick(3);
    clk_en = 1'b1;
    host_model_inst.ctrl_wr(1'b0, 1'b1, 1'b0);
    check(mode, MODE_HIGH_Z);
    check(drive.switcher_on, 1'b0);
    host_model_inst.ctrl_wr(1'b0, 1'b0, 1'b1);
    check(mode, MODE_BOOST);
    check(drive.boost_on, 1'b1);
    host_model_inst.ctrl_wr(1'b1, 1'b0, 1'b0);
    host_model_inst.ctrl_wr(1'b0, 1'b0, 1'b0);
    check(cycle_start, 1'b1);
    check(mode, MODE_CHARGE);
    wrap_up();
  end
endmodule
`default_nettype wire
